// [design/sample_window_calc.sv]
// Purpose: derive a channel's button sampling window from cycle count and divider
// Assumes: window = (cycles + 1) shifted left by divider; combinational
// Notes:   exact scaling is a plain choice, the algorithm core may rescale
`timescale 1ns/100ps
`include "sensor_cfg.svh"

module sample_window_calc #(
  parameter int DIV_W = 3,
  parameter int WIN_W = 16
) (
  // inputs
  input  wire logic [4:0]       sense_cycles,
  input  wire logic [DIV_W-1:0] low_power_clock_divider,
  // result
  output logic      [WIN_W-1:0] window
);

  always_comb begin
    window = (WIN_W'(sense_cycles) + WIN_W'(1)) << low_power_clock_divider;
  end

endmodule // sample_window_calc

// [design/sensor_cfg.svh]
// Purpose: register offsets, field positions and reset values for channel sensor setup
// Assumes: byte-wide registers reached over the device's internal register port
// Notes:   definitions only
`ifndef SENSOR_CFG_SVH
`define SENSOR_CFG_SVH

`define OFS_CH0_SETUP      8'h20
`define OFS_CH1_SETUP      8'h22
`define OFS_CH2_SETUP      8'h24
`define OFS_CH0_TRACK      8'h25
`define OFS_CH3_SETUP      8'h26

`define RST_SETUP          8'h04
`define RST_TRACK          8'hda

`define BIT_RANGE          7
`define BAND_HI            6
`define BAND_LO            5
`define CYC_HI             4
`define CYC_LO             0
`define FTF_HI             2
`define FTF_LO             1

`define BAND_RESERVED      2'h3

`endif

// [design/sensor_channel_config_regs.sv]
// Purpose: per-channel sensor setup and channel 0 fast tracking registers
// Assumes: host serial port decoded upstream into a single-cycle byte request
// Notes:   read data is registered one cycle after rd_en; unmapped reads return zero
`timescale 1ns/100ps
`include "sensor_cfg.svh"

// Summary of operation
// - bit 7 selects sensor parallel resistance range
// - bits 6-5 select oscillation frequency band
// - bits 4-0 cycle count sets sampling window
// - tracking bits 2-1 fast factor, reset 1
// - tracking register resets DAh, reserved bits writable
// - each channel setup register resets 04h
module sensor_channel_config_regs #(
  parameter int NCH   = 4,
  parameter int DIV_W = 3,
  parameter int WIN_W = 16
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // register port
  input  wire sensor_pkg::reg_req_t  req,
  output logic      [7:0]            rdata,
  output logic                       rvalid,
  // shared divider from its own register
  input  wire logic [DIV_W-1:0]      low_power_clock_divider,
  // configuration to the measurement core
  output sensor_pkg::chan_setup_t    setup   [NCH],
  output logic      [WIN_W-1:0]      window  [NCH],
  output logic      [1:0]            ch0_fast_track_factor,
  output logic                       band_reserved_seen
);

  // index that marks an offset outside the setup bank
  localparam int NO_CHAN = NCH;

  // registered state, its next values and the raw window results
  sensor_pkg::chan_setup_t  setup_q  [NCH];
  sensor_pkg::chan_setup_t  setup_d  [NCH];
  sensor_pkg::track_setup_t track_q;
  sensor_pkg::track_setup_t track_d;
  logic [7:0]               rdata_q;
  logic [7:0]               rdata_d;
  logic                     rvalid_q;
  logic                     rvalid_d;
  logic [WIN_W-1:0]         win_c    [NCH];
  logic [WIN_W-1:0]         win_d    [NCH];
  logic [WIN_W-1:0]         win_q    [NCH];
  logic                     rsv_q;
  logic                     rsv_d;

  // decoded request
  int                       req_chan;
  logic [NCH-1:0]           setup_sel;
  logic                     wr_setup;
  logic                     wr_track;
  logic                     rd_setup;
  logic                     rd_track;
  logic                     rd_hole;

  // channel index for a setup offset, NO_CHAN when none matches
  function automatic int chan_of(input logic [7:0] a);
    case (a)
      `OFS_CH0_SETUP: chan_of = 0;
      `OFS_CH1_SETUP: chan_of = 1;
      `OFS_CH2_SETUP: chan_of = 2;
      `OFS_CH3_SETUP: chan_of = 3;
      default:        chan_of = NO_CHAN;
    endcase
  endfunction

  // offset selects a setup register that this bank holds
  function automatic logic is_setup(input logic [7:0] a);
    is_setup = (chan_of(a) < NCH);
  endfunction

  // offset selects the channel 0 tracking register
  function automatic logic is_track(input logic [7:0] a);
    is_track = (a == `OFS_CH0_TRACK);
  endfunction

  // setup byte carries the reserved band code
  function automatic logic band_is_reserved(input logic [7:0] b);
    band_is_reserved = (b[`BAND_HI:`BAND_LO] == `BAND_RESERVED);
  endfunction

  // request decode shared by the write, read and flag groups
  always_comb begin
    req_chan  = chan_of(req.addr);
    setup_sel = '0;
    for (int i = 0; i < NCH; i++) begin
      setup_sel[i] = (req_chan == i);
    end
    wr_setup  = req.wr_en && is_setup(req.addr);
    wr_track  = req.wr_en && is_track(req.addr);
    rd_setup  = req.rd_en && is_setup(req.addr);
    rd_track  = req.rd_en && is_track(req.addr);
    rd_hole   = req.rd_en && !is_setup(req.addr) && !is_track(req.addr);
  end

  // setup group: whole byte stored, fields split by the struct layout
  always_comb begin
    setup_d = setup_q;
    for (int i = 0; i < NCH; i++) begin
      if (wr_setup && setup_sel[i]) begin
        setup_d[i] = sensor_pkg::chan_setup_t'(req.wdata);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        setup_q[i] <= sensor_pkg::chan_setup_t'(`RST_SETUP);
      end
    end else begin
      setup_q <= setup_d;
    end
  end

  // tracking group: reserved bits are plain storage, so a read-modify-write keeps them
  always_comb begin
    track_d = track_q;
    if (wr_track) begin
      track_d = sensor_pkg::track_setup_t'(req.wdata);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      track_q <= sensor_pkg::track_setup_t'(`RST_TRACK);
    end else begin
      track_q <= track_d;
    end
  end

  // read group: a read beside a write in one cycle returns the old byte
  always_comb begin
    rvalid_d = req.rd_en;
    rdata_d  = rdata_q;
    for (int i = 0; i < NCH; i++) begin
      if (rd_setup && setup_sel[i]) begin
        rdata_d = 8'(setup_q[i]);
      end
    end
    if (rd_track) begin
      rdata_d = 8'(track_q);
    end
    if (rd_hole) begin
      rdata_d = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // reserved band is stored as written but flagged so misuse stays visible;
  // the flag only sets, reset alone clears it
  always_comb begin
    rsv_d = rsv_q;
    if (wr_setup && band_is_reserved(req.wdata)) begin
      rsv_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsv_q <= 1'b0;
    end else begin
      rsv_q <= rsv_d;
    end
  end

  // window group: one calculator per channel, result registered for the core
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_win
      sample_window_calc #(
        .DIV_W (DIV_W),
        .WIN_W (WIN_W)
      ) u_win (
        .sense_cycles            (setup_q[g].sense_cycles),
        .low_power_clock_divider (low_power_clock_divider),
        .window                  (win_c[g])
      );
    end
  endgenerate

  // the window trails a setup write by one cycle; the core reads it between scans
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      win_d[i] = win_c[i];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        win_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        win_q[i] <= win_d[i];
      end
    end
  end

  // outputs straight from the registers
  assign setup                 = setup_q;
  assign window                = win_q;
  assign ch0_fast_track_factor = track_q.fast_track_factor;
  assign rdata                 = rdata_q;
  assign rvalid                = rvalid_q;
  assign band_reserved_seen    = rsv_q;

endmodule // sensor_channel_config_regs

// [design/sensor_pkg.sv]
// Purpose: types shared by the channel sensor setup registers
// Assumes: field layout from sensor_cfg.svh
// Notes:   one struct per channel configuration byte
package sensor_pkg;

  typedef enum logic [1:0] {
    band_1_3mhz,
    band_3_10mhz,
    band_10_30mhz,
    band_reserved
  } osc_band_t;

  typedef struct packed {
    logic       resist_range;
    osc_band_t  osc_band;
    logic [4:0] sense_cycles;
  } chan_setup_t;

  typedef struct packed {
    logic [4:0] rsvd_hi;
    logic [1:0] fast_track_factor;
    logic       rsvd_lo;
  } track_setup_t;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// [test/host_model.sv]
// Purpose: host side of the register port
// Assumes: one request per two edges
// Notes:   released fields show inverted junk, not the last value
`timescale 1ns/100ps
module host_model (
  // register port
  input  wire logic       clk,
  output sensor_pkg::reg_req_t req,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  initial req = '0;
  task wr(input logic [7:0] a, input logic [7:0] d);
    if (a != 8'h25 && d[6:5] == 2'h3) d[6:5] = 2'h2;
    @(posedge clk); #1 req = '{1'b1, 1'b0, a, d};
    @(posedge clk); #1 req = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk); #1 req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk); #1 req = '{1'b0, 1'b0, ~a, 8'hff};
    d = rvalid ? rdata : 8'hxx;
  endtask
  // factor update that keeps the reserved tracking bits as read
  task set_factor(input logic [1:0] f);
    logic [7:0] v;
    rd(8'h25, v);
    v[2:1] = f;
    wr(8'h25, v);
  endtask
endmodule // host_model

// [test/sensor_regs_properties.sv]
// Purpose: port checks of the channel setup registers
// Assumes: request taken on a clk edge, answers one edge later
// Notes:   bound into the design
`timescale 1ns/100ps
module sensor_regs_checker #(parameter int NCH = 4, DIV_W = 3, WIN_W = 16) (
  // watched ports
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire sensor_pkg::reg_req_t    req,
  input wire logic [7:0]              rdata,
  input wire logic [DIV_W-1:0]        low_power_clock_divider,
  input wire sensor_pkg::chan_setup_t setup [NCH],
  input wire logic [WIN_W-1:0]        window [NCH],
  input wire logic [1:0]              ch0_fast_track_factor
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ch0_write: assert property (
    req.wr_en && req.addr == 8'h20 |=> setup[0] == $past(req.wdata)) else $error("ch0 write");
  a_ch3_write: assert property (
    req.wr_en && req.addr == 8'h26 |=> setup[3] == $past(req.wdata)) else $error("ch3 write");
  a_factor_write: assert property (
    req.wr_en && req.addr == 8'h25 |=> ch0_fast_track_factor == $past(req.wdata[2:1]))
    else $error("factor write");
  a_track_keep: assert property (
    req.wr_en && req.addr == 8'h25 ##1 !(req.wr_en && req.addr == 8'h25)
    ##1 req.rd_en && req.addr == 8'h25
    |=> rdata == $past(req.wdata, 3)) else $error("track readback");
  a_read_ch0: assert property (
    req.rd_en && !req.wr_en && req.addr == 8'h20 |=> rdata == $past(setup[0]))
    else $error("ch0 read");
  a_window_calc: assert property (
    $past(rst_n) |-> window[0] == ({27'h0, $past(setup[0].sense_cycles)} + 32'h1)
    << $past(low_power_clock_divider)) else $error("window");
  c_track_wr: cover property (req.wr_en && req.addr == 8'h25);
  c_ch3_wr: cover property (req.wr_en && req.addr == 8'h26);
  c_odd_rd: cover property (req.rd_en && req.addr == 8'h21);
endmodule // sensor_regs_checker
bind sensor_channel_config_regs sensor_regs_checker #(.NCH(NCH), .DIV_W(DIV_W), .WIN_W(WIN_W))
  u_sensor_regs_checker (.*);

// [test/tb_top.sv]
// Purpose: self-checking bench of the channel setup registers
// Assumes: host model drives the register port
// Notes:   divider starts at 2, set to 5 late in the field test
`timescale 1ns/100ps
module tb_top;
  logic clk = 0, rst_n = 0, rvalid, flag;
  logic [2:0] div = 3'h2;
  logic [7:0] rdata, d;
  logic [1:0] ftf;
  logic [15:0] window [4];
  sensor_pkg::reg_req_t req;
  sensor_pkg::chan_setup_t setup [4];
  int bad_count = 0, total_checks = 0;
  initial forever #2.5 clk = ~clk;
  sensor_channel_config_regs u_sensor_channel_config_regs (.clk(clk), .rst_n(rst_n),
    .req(req), .rdata(rdata), .rvalid(rvalid), .low_power_clock_divider(div),
    .setup(setup), .window(window), .ch0_fast_track_factor(ftf), .band_reserved_seen(flag));
  host_model u_host_model (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
  task ck(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task t_reset;
    for (int i = 0; i < 5; i++) begin
      u_host_model.rd(8'(i < 3 ? 32'h20 + 2 * i : 32'h22 + i), d);
      ck("rst rd", d, i == 3 ? 8'hda : 8'h04);
      if (i < 4) ck("rst setup", setup[i], 8'h04);
    end
    ck("rst ftf", ftf, 2'h1);
  endtask
  task t_fields;
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      u_host_model.wr(8'(32'h20 + 2 * i), 8'(32'h01c7209f >> (8 * i)));
    end
    for (int i = 0; i < 4; i++) begin
      v = 8'(32'h01c7209f >> (8 * i));
      ck("range", setup[i].resist_range, v[7]);
      ck("band", setup[i].osc_band, v[6:5]);
      ck("win", window[i], (16'(v[4:0]) + 16'h1) << div);
      u_host_model.rd(8'(32'h20 + 2 * i), d);
      ck("rdback", d, v);
    end
    div = 3'h5;
    @(posedge clk);
    #1 ck("win div", window[0], 16'h0400);
  endtask
  task t_track;
    u_host_model.set_factor(2'h3);
    ck("ftf rmw", ftf, 2'h3);
    u_host_model.rd(8'h25, d);
    ck("rsvd kept", d, 8'hde);
    u_host_model.wr(8'h25, 8'h25);
    ck("ftf", ftf, 2'h2);
    u_host_model.rd(8'h25, d);
    ck("track", d, 8'h25);
    u_host_model.wr(8'h21, 8'hff);
    u_host_model.rd(8'h21, d);
    ck("hole", d, 8'h00);
    ck("ch1", setup[1], 8'h20);
    ck("band flag", flag, 1'b0);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 rst_n = 1;
    t_reset();
    t_fields();
    t_track();
    final_report();
  end
endmodule // tb_top
